// ==== touch_cfg_defines.svh ====
// Register map, field positions and reset values of the touch configuration block
`ifndef TOUCH_CFG_DEFINES_SVH
`define TOUCH_CFG_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_GENERAL_CONFIG_TWO 8'h40
`define IDX_GROUPED_CHANNEL_ENABLE 8'h41
`define IDX_NEAR_FIELD_CONTROL 8'h42
`define ADDR_GENERAL_CONFIG_TWO 12'h100
`define ADDR_GROUPED_CHANNEL_ENABLE 12'h104
`define ADDR_NEAR_FIELD_CONTROL 12'h108

`define RST_GENERAL_CONFIG_TWO 8'h00
`define RST_GROUPED_CHANNEL_ENABLE 8'h7f
`define RST_NEAR_FIELD_CONTROL 8'h02
`define MASK_GENERAL_CONFIG_TWO 8'h9f
`define MASK_GROUPED_CHANNEL_ENABLE 8'h7f
`define MASK_NEAR_FIELD_CONTROL 8'hff

// General config two fields
`define BIT_LINKED_TRANSITION_INVERT 7
`define BIT_POLARITY_MIRROR_DECOUPLE 4
`define BIT_RADIO_NOISE_ONLY_STATUS 3
`define BIT_RADIO_NOISE_BLOCK_DISABLE 2
`define BIT_GROUP_AS_BUTTONS 1
`define BIT_RELEASE_INTERRUPT_SUPPRESS 0

// Near field control fields
`define BIT_CHANNEL_ONE_NEAR_MODE 7
`define BIT_NEAR_SUM_SELECT 6
`define POS_NEAR_AVERAGE_COUNT 3
`define POS_NEAR_SENSITIVITY 0

`define NEAR_AVG_BASE 8'h10
`define NEAR_AVG_BASE_SHIFT 5'h04
`define NEAR_BOOST_SHIFT 3

`endif

// ==== touch_cfg_pkg.sv ====
// Types shared by the touch configuration block
`default_nettype none
package touch_cfg_pkg;

  typedef enum logic [1:0] {
    AVG_IDLE = 2'b01,
    AVG_RUN = 2'b10
  } avg_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic up;
    logic down;
    logic tap;
    logic hold;
  } slide_status_t;

  typedef struct packed {
    logic [7:0] cfg2;
    logic [7:0] gen;
    logic [7:0] prox;
    apb_rsp_t rsp;
    logic [10:0] mirror;
    logic link_touch;
    logic link_min_eq_max;
    logic [13:0] touch_valid;
    logic [13:0] touch_prev;
    logic [13:0] noise_status;
    logic cal_retry;
    logic [13:0] btn_status;
    logic int_pulse;
    slide_status_t status;
    logic [6:0] sample_en;
    logic [6:0] uses_queue;
    logic [6:0] max_hold_apply;
    logic ch1_bypass;
    logic [2:0] delta_scale;
    avg_state_t avg_state;
    logic [7:0] avg_cnt;
    logic [25:0] acc;
    logic [25:0] near_result;
    logic near_valid;
    logic near_detect;
    logic resample;
  } state_t;

endpackage
`default_nettype wire

// ==== touch_group_proximity_config.sv ====
// APB register block and event logic for grouped sensors and channel-one proximity
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "touch_cfg_defines.svh"

// Summary of operation
// RQ1 - Bit 7 inverts linked touch, else min=max
// RQ2 - Polarity writes copy into mirror unless decoupled
// RQ3 - Bit 3 limits noise status to RF
// RQ4 - RF noise blocks touch, retries calibration
// RQ5 - Bit 2 set: RF noise ignored
// RQ6 - Slider mode: group sampled, group threshold
// RQ7 - Button mode: per-sensor interrupt, status, enable
// RQ8 - Button mode: no slide status from group
// RQ9 - Channels 8,14 tap logic; others queue
// RQ10 - Group max hold applies in button mode
// RQ11 - Channels 8,14: press and repeat, no release
// RQ12 - Channel 8 sets down, 14 sets up
// RQ13 - Bit 0 suppresses release interrupts
// RQ14 - Group enable bits gate sampling, reset 7f
// RQ15 - Normal channel one: queue, averaging one
// RQ16 - Near mode: bypass queue, boost eight
// RQ17 - Sum select: sum or average compared
// RQ18 - Sample channel one count times, average
// RQ19 - Average code picks 16 to 128
// RQ20 - Sensitivity zero most, seven least
// RQ21 - Unused register bits read zero
module touch_group_proximity_config #(
  parameter int ADDR_W = 12
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire touch_cfg_pkg::apb_req_t apb_in,
  output touch_cfg_pkg::apb_rsp_t apb_out,
  input wire logic led_polarity_write_in,
  input wire logic [10:0] led_polarity_value_in,
  output logic [10:0] led_mirror_out,
  input wire logic link_touch_in,
  output logic link_touch_out,
  output logic link_min_eq_max_out,
  input wire logic [13:0] touch_raw_in,
  input wire logic [13:0] rf_noise_in,
  input wire logic [13:0] lf_noise_in,
  input wire logic analog_cal_active_in,
  output logic [13:0] touch_valid_out,
  output logic [13:0] noise_status_out,
  output logic cal_retry_out,
  input wire logic group_enable_in,
  input wire logic group_sleep_enable_in,
  input wire logic group_max_hold_enable_in,
  input wire logic button_repeat_tick_in,
  input wire logic group_repeat_tick_in,
  input wire touch_cfg_pkg::slide_status_t slide_event_in,
  input wire logic [1:0] tap_event_in,
  input wire logic [1:0] hold_event_in,
  output logic [13:0] button_status_out,
  output touch_cfg_pkg::slide_status_t slide_status_out,
  output logic int_pulse_out,
  output logic [6:0] sample_enable_out,
  output logic [6:0] uses_queue_out,
  output logic [6:0] max_hold_apply_out,
  input wire logic ch1_sample_valid_in,
  input wire logic [15:0] ch1_delta_in,
  input wire logic [15:0] near_threshold_in,
  output logic ch1_queue_bypass_out,
  output logic [2:0] near_delta_scale_out,
  output logic ch1_resample_out,
  output logic [25:0] near_result_out,
  output logic near_result_valid_out,
  output logic near_detect_out
);
  import touch_cfg_pkg::*;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie in 12..32");
  end

  state_t s_q;
  state_t s_d;

  logic as_buttons;
  logic rel_suppress;
  logic near_mode;
  logic [13:0] press;
  logic [13:0] release_ev;
  logic [13:0] int_req;
  logic [6:0] pair_btn;

  assign as_buttons = s_q.cfg2[`BIT_GROUP_AS_BUTTONS];
  assign rel_suppress = s_q.cfg2[`BIT_RELEASE_INTERRUPT_SUPPRESS];
  assign near_mode = s_q.prox[`BIT_CHANNEL_ONE_NEAR_MODE];
  assign press = s_q.touch_valid & ~s_q.touch_prev;
  assign release_ev = ~s_q.touch_valid & s_q.touch_prev;

  // Per-channel interrupt sources; index 7..13 are the grouped channels
  for (genvar i = 0; i < 14; i++) begin : g_int
    if (i < 7) begin : g_plain
      assign int_req[i] = press[i]
                        | (release_ev[i] & ~rel_suppress) // [RQ13]
                        | (s_q.touch_valid[i] & button_repeat_tick_in);
    end else if (i == 7 || i == 13) begin : g_pair
      // End sensors act like tap / hold: never a release interrupt
      assign pair_btn[i-7] = 1'b1;
      assign int_req[i] = as_buttons & s_q.gen[i-7]
                        & (press[i] | (s_q.touch_valid[i] & group_repeat_tick_in)); // [RQ11] [RQ9]
    end else begin : g_mid
      assign pair_btn[i-7] = 1'b0;
      assign int_req[i] = as_buttons & s_q.gen[i-7]
                        & (press[i]
                           | (release_ev[i] & ~rel_suppress) // [RQ13]
                           | (s_q.touch_valid[i] & button_repeat_tick_in)); // [RQ7] [RQ9]
    end
  end

  always_comb begin
    logic wr;
    logic rd_setup;
    logic hit;
    logic [7:0] rdata;
    logic [13:0] blk_rf;
    logic [13:0] stat_src;
    logic [25:0] sample;
    logic [25:0] total;
    logic [25:0] value;
    logic [7:0] navg;
    logic [4:0] avg_shift;
    logic slide_int;
    s_d = s_q;
    wr = 1'b0;
    rd_setup = 1'b0;
    hit = 1'b1;
    rdata = 8'h00;
    blk_rf = 14'h0000;
    stat_src = 14'h0000;
    sample = 26'h0000000;
    total = 26'h0000000;
    value = 26'h0000000;
    navg = 8'h01;
    avg_shift = 5'h00;
    slide_int = 1'b0;

    // APB slave: answer in the first cycle of the access phase
    rd_setup = apb_in.psel & ~apb_in.penable;
    wr = apb_in.psel & apb_in.penable & apb_in.pwrite & s_q.rsp.pready;
    if (apb_in.paddr == `ADDR_GENERAL_CONFIG_TWO) begin
      rdata = s_q.cfg2;
    end else if (apb_in.paddr == `ADDR_GROUPED_CHANNEL_ENABLE) begin
      rdata = s_q.gen;
    end else if (apb_in.paddr == `ADDR_NEAR_FIELD_CONTROL) begin
      rdata = s_q.prox;
    end else begin
      hit = 1'b0;
    end
    s_d.rsp.pready = rd_setup;
    s_d.rsp.pslverr = rd_setup & ~hit;
    s_d.rsp.prdata = rd_setup ? {24'h000000, rdata} : 32'h00000000;
    if (wr && hit) begin
      if (apb_in.paddr == `ADDR_GENERAL_CONFIG_TWO) begin
        s_d.cfg2 = apb_in.pwdata[7:0] & `MASK_GENERAL_CONFIG_TWO; // [RQ21]
      end else if (apb_in.paddr == `ADDR_GROUPED_CHANNEL_ENABLE) begin
        s_d.gen = apb_in.pwdata[7:0] & `MASK_GROUPED_CHANNEL_ENABLE; // [RQ14] [RQ21]
      end else begin
        s_d.prox = apb_in.pwdata[7:0] & `MASK_NEAR_FIELD_CONTROL;
      end
    end

    // LED coupling
    if (s_q.cfg2[`BIT_LINKED_TRANSITION_INVERT]) begin
      s_d.link_touch = ~link_touch_in; // [RQ1]
      s_d.link_min_eq_max = 1'b0;
    end else begin
      s_d.link_touch = link_touch_in;
      s_d.link_min_eq_max = 1'b1; // [RQ1]
    end
    if (led_polarity_write_in && !s_q.cfg2[`BIT_POLARITY_MIRROR_DECOUPLE]) begin
      s_d.mirror = led_polarity_value_in; // [RQ2]
    end

    // Noise handling; low-frequency noise always blocks
    if (!s_q.cfg2[`BIT_RADIO_NOISE_BLOCK_DISABLE]) begin
      blk_rf = rf_noise_in; // [RQ4]
    end
    s_d.touch_valid = touch_raw_in & ~lf_noise_in & ~blk_rf; // [RQ3] [RQ5]
    s_d.cal_retry = analog_cal_active_in & (|blk_rf); // [RQ4] [RQ5]
    if (s_q.cfg2[`BIT_RADIO_NOISE_ONLY_STATUS]) begin
      stat_src = rf_noise_in; // [RQ3]
    end else begin
      stat_src = rf_noise_in | lf_noise_in;
    end
    s_d.noise_status = stat_src;
    s_d.touch_prev = s_q.touch_valid;

    // Grouped sensors
    if (group_enable_in && !group_sleep_enable_in) begin
      s_d.sample_en = s_q.gen[6:0]; // [RQ6] [RQ14]
    end else begin
      s_d.sample_en = 7'h00;
    end
    s_d.btn_status[6:0] = s_q.touch_valid[6:0];
    if (as_buttons) begin
      s_d.btn_status[13:7] = s_q.touch_valid[13:7] & s_q.gen[6:0]; // [RQ7]
      s_d.uses_queue = ~pair_btn; // [RQ9]
      s_d.max_hold_apply = {7{group_max_hold_enable_in}}; // [RQ10]
      // Only the end sensors feed up / down; slides are ignored
      s_d.status.up = tap_event_in[1] | hold_event_in[1]; // [RQ12] [RQ8]
      s_d.status.down = tap_event_in[0] | hold_event_in[0]; // [RQ12] [RQ8]
      s_d.status.tap = |tap_event_in;
      s_d.status.hold = |hold_event_in;
    end else begin
      s_d.btn_status[13:7] = 7'h00; // [RQ6]
      s_d.uses_queue = 7'h00;
      s_d.max_hold_apply = 7'h00;
      s_d.status = slide_event_in;
      slide_int = |slide_event_in;
    end
    s_d.int_pulse = (|int_req) | slide_int | (as_buttons & (|tap_event_in | |hold_event_in));

    // Channel one: near mode trades polling time for resolution
    s_d.ch1_bypass = near_mode; // [RQ16] [RQ15]
    s_d.delta_scale = s_q.prox[2:0];
    if (near_mode) begin
      navg = `NEAR_AVG_BASE << s_q.prox[4:3]; // [RQ19]
      avg_shift = `NEAR_AVG_BASE_SHIFT + {3'h0, s_q.prox[4:3]};
      sample = {7'h00, ch1_delta_in, 3'h0}; // [RQ16]
    end else begin
      sample = {10'h000, ch1_delta_in}; // [RQ15]
    end
    total = s_q.acc + sample;
    s_d.near_valid = 1'b0;
    case (s_q.avg_state)
      AVG_IDLE: begin
        if (ch1_sample_valid_in) begin
          if (navg == 8'h01) begin
            s_d.near_valid = 1'b1;
            s_d.near_result = total;
            s_d.near_detect = total >= {10'h000, near_threshold_in};
          end else begin
            s_d.acc = total;
            s_d.avg_cnt = 8'h01;
            s_d.avg_state = AVG_RUN;
          end
        end
      end
      AVG_RUN: begin
        if (ch1_sample_valid_in) begin
          if (s_q.avg_cnt == navg - 8'h01) begin
            if (s_q.prox[`BIT_NEAR_SUM_SELECT]) begin
              value = total; // [RQ17]
            end else begin
              value = total >> avg_shift; // [RQ17] [RQ18]
            end
            value = value >> s_q.prox[2:0]; // [RQ20]
            s_d.near_result = value;
            s_d.near_detect = value >= {10'h000, near_threshold_in};
            s_d.near_valid = 1'b1;
            s_d.acc = 26'h0000000;
            s_d.avg_cnt = 8'h00;
            s_d.avg_state = AVG_IDLE;
          end else begin
            s_d.acc = total; // [RQ18]
            s_d.avg_cnt = s_q.avg_cnt + 8'h01;
          end
        end
      end
      default: begin
        s_d.avg_state = AVG_IDLE;
      end
    endcase
    if (!near_mode && s_q.avg_state == AVG_RUN) begin
      s_d.avg_state = AVG_IDLE;
      s_d.acc = 26'h0000000;
      s_d.avg_cnt = 8'h00;
    end
    s_d.resample = s_d.avg_state == AVG_RUN; // [RQ18]
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      s_q.cfg2 <= `RST_GENERAL_CONFIG_TWO;
      s_q.gen <= `RST_GROUPED_CHANNEL_ENABLE; // [RQ14]
      s_q.prox <= `RST_NEAR_FIELD_CONTROL;
      s_q.link_min_eq_max <= 1'b1;
      s_q.delta_scale <= 3'h2;
      s_q.avg_state <= AVG_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_out = s_q.rsp;
  assign led_mirror_out = s_q.mirror;
  assign link_touch_out = s_q.link_touch;
  assign link_min_eq_max_out = s_q.link_min_eq_max;
  assign touch_valid_out = s_q.touch_valid;
  assign noise_status_out = s_q.noise_status;
  assign cal_retry_out = s_q.cal_retry;
  assign button_status_out = s_q.btn_status;
  assign slide_status_out = s_q.status;
  assign int_pulse_out = s_q.int_pulse;
  assign sample_enable_out = s_q.sample_en;
  assign uses_queue_out = s_q.uses_queue;
  assign max_hold_apply_out = s_q.max_hold_apply;
  assign ch1_queue_bypass_out = s_q.ch1_bypass;
  assign near_delta_scale_out = s_q.delta_scale;
  assign ch1_resample_out = s_q.resample;
  assign near_result_out = s_q.near_result;
  assign near_result_valid_out = s_q.near_valid;
  assign near_detect_out = s_q.near_detect;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_link_invert;
    s_q.cfg2[7] |=> link_touch_out == !$past(link_touch_in);
  endproperty
  a_link_invert: assert property (p_link_invert) else $error("linked touch not inverted"); // [RQ1]

  property p_mirror;
    led_polarity_write_in && !s_q.cfg2[4] |=> led_mirror_out == $past(led_polarity_value_in);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror not coupled"); // [RQ2]

  property p_noise_only_rf;
    s_q.cfg2[3] && lf_noise_in[0] && !rf_noise_in[0] |=> !noise_status_out[0] && !touch_valid_out[0];
  endproperty
  a_noise_only_rf: assert property (p_noise_only_rf) else $error("lf noise shown"); // [RQ3]

  property p_rf_block;
    !s_q.cfg2[2] && rf_noise_in[1] && analog_cal_active_in |=> !touch_valid_out[1] && cal_retry_out;
  endproperty
  a_rf_block: assert property (p_rf_block) else $error("rf noise not blocking"); // [RQ4]

  property p_rf_pass;
    s_q.cfg2[2] && touch_raw_in[1] && !lf_noise_in[1] |=> touch_valid_out[1];
  endproperty
  a_rf_pass: assert property (p_rf_pass) else $error("touch blocked"); // [RQ5]

  property p_no_slide;
    s_q.cfg2[1] && slide_event_in.up && !tap_event_in[1] && !hold_event_in[1] |=> !slide_status_out.up;
  endproperty
  a_no_slide: assert property (p_no_slide) else $error("slide in button mode"); // [RQ8]

  property p_down;
    s_q.cfg2[1] && tap_event_in[0] |=> slide_status_out.down && slide_status_out.tap && int_pulse_out;
  endproperty
  a_down: assert property (p_down) else $error("down not set"); // [RQ12]

  property p_enable_reset;
    $rose(reset_n_in) |-> s_q.gen == 8'h7f;
  endproperty
  a_enable_reset: assert property (disable iff (1'b0) p_enable_reset) else $error("bad enable reset"); // [RQ14]

  property p_bypass;
    s_q.prox[7] |=> ch1_queue_bypass_out ##1 ch1_queue_bypass_out || !s_q.prox[7];
  endproperty
  a_bypass: assert property (p_bypass) else $error("queue not bypassed"); // [RQ16]

  property p_cov_write;
    apb_in.psel && apb_in.penable && apb_in.pwrite && apb_out.pready;
  endproperty
  c_write: cover property (p_cov_write);
  property p_cov_avg;
    near_result_valid_out && s_q.prox[7];
  endproperty
  c_avg: cover property (p_cov_avg);
  property p_cov_btn;
    s_q.cfg2[1] && int_pulse_out;
  endproperty
  c_btn: cover property (p_cov_btn);

endmodule
`default_nettype wire

// ==== touch_host_model.sv ====
// Host model: APB master that reads and writes the configuration registers
`timescale 1ns/1ns
`default_nettype none
module touch_host_model (
  input wire logic clock_in,
  input wire touch_cfg_pkg::apb_rsp_t apb_in,
  output var touch_cfg_pkg::apb_req_t apb_out
);
  import touch_cfg_pkg::*;
  initial apb_out = '0;
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    apb_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock_in);
    apb_out.penable <= 1'b1;
    // No own limit: the bench timeout ends a hung wait
    do begin
      @(posedge clock_in);
    end while (apb_in.pready !== 1'b1);
    rd = apb_in.prdata;
    err = apb_in.pslverr;
    // Released bus shows inverted values so a slave latching late is caught
    apb_out <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~wd};
  endtask
endmodule
`default_nettype wire

// ==== tb_touch_group_proximity_config.sv ====
// Self-checking bench for the grouped sensor and proximity configuration block
`timescale 1ns/1ns
`default_nettype none
`include "touch_cfg_defines.svh"
module tb_touch_group_proximity_config;
  import touch_cfg_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  apb_req_t req;
  apb_rsp_t rsp;
  logic pol_wr = 0, lt = 0, cal = 0, gen_en = 1, sleep = 0, mh = 0, sv = 0, brt = 0, grt = 0;
  logic [10:0] pol = '0, mir;
  logic [13:0] traw = '0, rf = '0, lf = '0, tv, ns, bs;
  slide_status_t sev = '0, sst;
  logic [1:0] tap = '0, hold = '0;
  logic [15:0] delta = '0, thr = 16'h0001;
  logic lto, lmm, cr, ip, byp, rsmp, rv, det;
  logic [6:0] se, uq, mha;
  logic [2:0] dsc;
  logic [25:0] res;
  int fail_count = 0, cmp_count = 0, ints = 0, cyc = 0, rs_cnt = 0;
  always #4 clock_in = ~clock_in;
  touch_host_model touch_host_model_i (.clock_in(clock_in), .apb_in(rsp), .apb_out(req));
  // Repeat ticks and hold events are pulsed by hand; their real timing belongs to other blocks
  touch_group_proximity_config touch_group_proximity_config_i (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .apb_in(req), .apb_out(rsp),
    .led_polarity_write_in(pol_wr), .led_polarity_value_in(pol), .led_mirror_out(mir),
    .link_touch_in(lt), .link_touch_out(lto), .link_min_eq_max_out(lmm),
    .touch_raw_in(traw), .rf_noise_in(rf), .lf_noise_in(lf), .analog_cal_active_in(cal),
    .touch_valid_out(tv), .noise_status_out(ns), .cal_retry_out(cr),
    .group_enable_in(gen_en), .group_sleep_enable_in(sleep), .group_max_hold_enable_in(mh),
    .button_repeat_tick_in(brt), .group_repeat_tick_in(grt), .slide_event_in(sev),
    .tap_event_in(tap), .hold_event_in(hold), .button_status_out(bs), .slide_status_out(sst),
    .int_pulse_out(ip), .sample_enable_out(se), .uses_queue_out(uq), .max_hold_apply_out(mha),
    .ch1_sample_valid_in(sv), .ch1_delta_in(delta), .near_threshold_in(thr),
    .ch1_queue_bypass_out(byp), .near_delta_scale_out(dsc), .ch1_resample_out(rsmp),
    .near_result_out(res), .near_result_valid_out(rv), .near_detect_out(det));
  always @(posedge clock_in) begin
    if (ip === 1'b1) ints <= ints + 1;
    if (rsmp === 1'b1) rs_cnt <= rs_cnt + 1;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic done(input string t);
    $display("test %s ended, mismatches so far %0d", t, fail_count);
  endtask
  // Upper data bits are set on purpose; only the low byte may land
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    touch_host_model_i.xfer(1'b1, a, {24'hffffff, d}, r, e);
    cy(2);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    touch_host_model_i.xfer(1'b0, a, 32'h0, r, e);
    check("prdata", r, exp);
    check("pslverr", e, ee);
  endtask
  task automatic polw(input logic [10:0] v);
    @(posedge clock_in);
    pol <= v;
    pol_wr <= 1'b1;
    @(posedge clock_in);
    pol_wr <= 1'b0;
    cy(2);
  endtask
  task automatic ev(input slide_status_t s, input logic [1:0] t, input logic [1:0] h, input slide_status_t exp);
    @(posedge clock_in);
    sev <= s;
    tap <= t;
    hold <= h;
    @(posedge clock_in);
    sev <= '0;
    tap <= '0;
    hold <= '0;
    #1;
    check("slide_status", sst, exp);
  endtask
  task automatic tch(input int b, input logic v, input int exp);
    int c;
    c = ints;
    @(posedge clock_in);
    traw[b] <= v;
    cy(5);
    check("interrupts", ints - c, exp);
    check("button_status", bs[b], v);
  endtask
  // One repeat tick: g picks the group tick, else the button tick
  task automatic rpt(input logic g, input int exp);
    int c;
    c = ints;
    @(posedge clock_in);
    grt <= g;
    brt <= ~g;
    @(posedge clock_in);
    grt <= 1'b0;
    brt <= 1'b0;
    cy(4);
    check("repeat_interrupts", ints - c, exp);
  endtask
  task automatic near(input int n, input logic [15:0] d, input logic [25:0] exp);
    int k;
    int c;
    c = rs_cnt;
    @(posedge clock_in);
    delta <= d;
    sv <= 1'b1;
    repeat (n) @(posedge clock_in);
    sv <= 1'b0;
    #1;
    k = 0;
    while (rv !== 1'b1 && k < 10) begin
      cy(1);
      k++;
    end
    check("near_result", res, exp);
    check("near_valid", rv, 1'b1);
    check("resample_cycles", rs_cnt - c, n - 1);
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    cy(2);
    rd(`ADDR_GENERAL_CONFIG_TWO, 32'h0, 1'b0);
    rd(`ADDR_GROUPED_CHANNEL_ENABLE, 32'h7f, 1'b0);
    rd(`ADDR_NEAR_FIELD_CONTROL, 32'h02, 1'b0);
    check("min_eq_max", lmm, 1'b1);
    check("sample_enable", se, 7'h7f);
    done("reset");
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'hff);
    wr(`ADDR_GROUPED_CHANNEL_ENABLE, 8'hff);
    wr(12'h10c, 8'hff);
    rd(`ADDR_GENERAL_CONFIG_TWO, 32'h9f, 1'b0);
    rd(`ADDR_GROUPED_CHANNEL_ENABLE, 32'h7f, 1'b0);
    rd(12'h10c, 32'h0, 1'b1);
    done("masks");
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h00);
    @(posedge clock_in);
    lt <= 1'b1;
    cy(2);
    check("link_touch", lto, 1'b1);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h80);
    check("link_touch", lto, 1'b0);
    check("min_eq_max", lmm, 1'b0);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h00);
    polw(11'h5a5);
    check("mirror", mir, 11'h5a5);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h10);
    polw(11'h0f0);
    check("mirror", mir, 11'h5a5);
    done("link_mirror");
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h00);
    @(posedge clock_in);
    traw <= 14'h0003;
    lf <= 14'h0001;
    rf <= 14'h0002;
    cal <= 1'b1;
    cy(2);
    check("touch_valid", tv, 14'h0);
    check("noise", ns, 14'h3);
    check("cal_retry", cr, 1'b1);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h08);
    check("noise", ns, 14'h2);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h04);
    check("touch_valid", tv, 14'h2);
    check("cal_retry", cr, 1'b0);
    @(posedge clock_in);
    traw <= '0;
    lf <= '0;
    rf <= '0;
    cal <= 1'b0;
    done("noise");
    @(posedge clock_in);
    mh <= 1'b1;
    wr(`ADDR_GROUPED_CHANNEL_ENABLE, 8'h55);
    check("sample_enable", se, 7'h55);
    @(posedge clock_in);
    sleep <= 1'b1;
    cy(2);
    check("sample_enable", se, 7'h0);
    @(posedge clock_in);
    sleep <= 1'b0;
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h00);
    check("uses_queue", uq, 7'h0);
    ev(4'b1000, 2'b00, 2'b01, 4'b1000);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h02);
    check("uses_queue", uq, 7'h3e);
    check("max_hold", mha, 7'h7f);
    ev(4'b1000, 2'b00, 2'b00, 4'b0000);
    ev(4'b0000, 2'b01, 2'b00, 4'b0110);
    ev(4'b0000, 2'b10, 2'b00, 4'b1010);
    ev(4'b0000, 2'b00, 2'b01, 4'b0101);
    ev(4'b0000, 2'b00, 2'b10, 4'b1001);
    wr(`ADDR_GROUPED_CHANNEL_ENABLE, 8'h7f);
    done("group");
    tch(0, 1'b1, 1);
    rpt(1'b0, 1);
    rpt(1'b1, 0);
    tch(0, 1'b0, 1);
    tch(7, 1'b1, 1);
    rpt(1'b1, 1);
    rpt(1'b0, 0);
    tch(7, 1'b0, 0);
    wr(`ADDR_GENERAL_CONFIG_TWO, 8'h03);
    tch(0, 1'b1, 1);
    tch(0, 1'b0, 0);
    done("interrupts");
    @(posedge clock_in);
    thr <= 16'hffff;
    near(1, 16'h1234, 26'h1234);
    check("bypass", byp, 1'b0);
    check("detect", det, 1'b0);
    @(posedge clock_in);
    thr <= 16'h0001;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_NEAR_FIELD_CONTROL, 8'hc0 | 8'(c << 3));
      near(16 << c, 16'h1234, 26'h1234 << (7 + c));
    end
    check("bypass", byp, 1'b1);
    check("detect", det, 1'b1);
    wr(`ADDR_NEAR_FIELD_CONTROL, 8'h8b);
    check("scale", dsc, 3'h3);
    near(32, 16'h1234, 26'h1234);
    done("near");
    summarize();
  end
endmodule
`default_nettype wire
